// [hw/power_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pwr_seq_defines.svh"
// Summary of operation
// - all regulators off only when both power requests are low
// - each power request releases its own section from reset
// - buck, core and low-noise regulators on when either request is high
// - resource timers run from the low-power oscillator clock
// - requests combine clock requests, minimum mask and active request timer
// - each clock request maps to the resources producing that clock
// - four resource states; timer zero when stable, non-zero while ramping
// - a state change loads the timer with on-delay or off-delay
// - non-zero timers count down per tick; zero ends the ramp
// - zero delay switches a resource immediately without ramping
// - every tick first computes required set through dependency table
// - timer reaching zero clears ramp flag and inverts on flag
// - requested set compared with current states every tick
// - disable only enabled, unrequested resources with no powered dependents
// - enable only disabled, requested resources with all dependencies on
// - doze stops main clocks; oscillator keeps sequencer alive for wake
// - core state saved to retention storage before deep-sleep power off
// - wake events restore saved core state instead of reinitialising
// - power-down has all regulators off until requests re-enable them
// - in shutdown outputs are tristated and inputs disabled
// - power-on from shutdown is a cold start with nothing retained
// - active mode gates unused clocks and picks slowest adequate speed
module power_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int NUM_RES = 8,
    parameter int NUM_CLK = 4,
    parameter int RET_W   = 32
)(
    // clock and reset
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    // AHB-Lite slave
    input  wire logic               hsel_in,
    input  wire logic [31:0]        haddr_in,
    input  wire logic [1:0]         htrans_in,
    input  wire logic               hwrite_in,
    input  wire logic [2:0]         hsize_in,
    input  wire logic [31:0]        hwdata_in,
    input  wire logic               hready_in,
    output logic [31:0]             hrdata_out,
    output logic                    hreadyout_out,
    output logic                    hresp_out,
    // pins
    input  wire logic               low_power_oscillator_clock_in,
    input  wire logic               radio_power_request_in,
    input  wire logic               wlan_power_request_in,
    input  wire logic               ext_wake_in,
    input  wire logic               host_resume_in,
    // core side
    input  wire logic [NUM_CLK-1:0] clk_req_in,
    input  wire logic [RET_W-1:0]   core_state_in,
    output logic [RET_W-1:0]        core_state_out,
    output logic                    core_restore_out,
    // power control
    output logic                    core_buck_regulator_en_out,
    output logic                    core_linear_regulator_en_out,
    output logic                    low_noise_linear_regulator_en_out,
    output logic                    radio_rst_out,
    output logic                    wlan_rst_out,
    output logic [NUM_RES-1:0]      resource_en_out,
    output logic                    core_power_en_out,
    output logic                    main_clk_en_out,
    output logic [NUM_CLK-1:0]      clk_gate_en_out,
    output logic [1:0]              clk_speed_out,
    output logic                    io_oe_n_out,
    output logic                    input_en_out
);

    initial
    begin
        if (NUM_RES < 1 || NUM_RES > 8 || NUM_CLK < 1 || NUM_CLK > 4 || RET_W < 1 || RET_W > 32)
            $error("power_sequencer: parameters out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree
    pins_t pin_raw;
    pins_t s1_ff, s2_ff, s3_ff, pin_ff;
    assign pin_raw = '{low_power_oscillator_clock: low_power_oscillator_clock_in, radio: radio_power_request_in,
                       wlan: wlan_power_request_in, ext_wake: ext_wake_in,
                       host_resume: host_resume_in};

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            pin_ff <= '0;
        end
        else
        begin
            s1_ff  <= pin_raw;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            pin_ff <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & pin_ff);
        end
    end

    logic lpo_old_ff;
    logic tick;
    logic any_req;
    logic cold;
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            lpo_old_ff <= 1'b0;
        else
            lpo_old_ff <= pin_ff.low_power_oscillator_clock;
    end
    assign tick = pin_ff.low_power_oscillator_clock & ~lpo_old_ff;
    assign any_req = pin_ff.radio | pin_ff.wlan;
    assign cold = rst_in | ~any_req;

    ////////////////////////////////////////////////////////////////////////
    // register file
    bus_req_t               req_ff;
    logic [1:0]             mode_ff;
    logic [NUM_RES-1:0]     min_mask_ff;
    logic [`TMR_W-1:0]      tcnt_ff;
    logic [NUM_RES-1:0]     tmask_ff;
    logic [NUM_RES-1:0]     clk_map_ff [NUM_CLK];
    logic [`TMR_W-1:0]      on_dly_ff  [NUM_RES];
    logic [`TMR_W-1:0]      off_dly_ff [NUM_RES];
    logic [NUM_RES-1:0]     dep_ff     [NUM_RES];
    logic [NUM_RES-1:0]     on_ff, ramp_ff;
    pwr_state_t             st_ff;
    logic                   wake;
    logic                   wr;
    logic                   tmr_expire;

    assign wr = req_ff.valid & req_ff.write;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            req_ff <= '0;
        else if (hready_in)
            req_ff <= '{valid: hsel_in & htrans_in[1] & (hsize_in == 3'h2),
                        write: hwrite_in, addr: haddr_in[7:0]};
    end

    always_ff @(posedge mclk_in)
    begin
        if (cold)
        begin
            min_mask_ff <= NUM_RES'(`RST_MIN_MASK);
            tmask_ff    <= '0;
        end
        else if (wr && req_ff.addr == `OFS_MIN_MASK)
            min_mask_ff <= hwdata_in[NUM_RES-1:0];
        else if (wr && req_ff.addr == `OFS_TMR_MASK)
            tmask_ff <= hwdata_in[NUM_RES-1:0];
    end

    // a wake overrides a simultaneous mode write
    always_ff @(posedge mclk_in)
    begin
        if (cold)
            mode_ff <= MODE_ACTIVE;
        else if (wake)
            mode_ff <= MODE_ACTIVE;
        else if (wr && req_ff.addr == `OFS_CTRL)
            mode_ff <= hwdata_in[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    end

    // request timer counts ticks while non-zero
    always_ff @(posedge mclk_in)
    begin
        if (cold)
            tcnt_ff <= '0;
        else if (wr && req_ff.addr == `OFS_TMR_CNT)
            tcnt_ff <= hwdata_in[`TMR_W-1:0];
        else if (tick && tcnt_ff != '0)
            tcnt_ff <= tcnt_ff - 1'b1;
    end
    assign tmr_expire = tick && tcnt_ff == `TMR_W'(1);

    genvar g;
    generate
        for (g = 0; g < NUM_RES; g++)
        begin : g_res_regs
            always_ff @(posedge mclk_in)
            begin
                if (cold)
                begin
                    on_dly_ff[g]  <= `RST_DELAY;
                    off_dly_ff[g] <= `RST_DELAY;
                    dep_ff[g]     <= '0;
                end
                else if (wr && req_ff.addr == 8'(`OFS_RES_BASE + g * `RES_STRIDE))
                begin
                    on_dly_ff[g]  <= hwdata_in[15:0];
                    off_dly_ff[g] <= hwdata_in[31:16];
                end
                else if (wr && req_ff.addr == 8'(`OFS_RES_BASE + g * `RES_STRIDE + 4))
                    dep_ff[g] <= hwdata_in[NUM_RES-1:0] & ~(NUM_RES'(1) << g);
            end
        end
        for (g = 0; g < NUM_CLK; g++)
        begin : g_clk_regs
            always_ff @(posedge mclk_in)
            begin
                if (cold)
                    clk_map_ff[g] <= '0;
                else if (wr && req_ff.addr == 8'(`OFS_CLK_MAP + 4 * g))
                    clk_map_ff[g] <= hwdata_in[NUM_RES-1:0];
            end
        end
    endgenerate

    logic [31:0] nxt_rdata;
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        case (haddr_in[7:0])
            `OFS_CTRL:     nxt_rdata[1:0] = mode_ff;
            `OFS_MIN_MASK: nxt_rdata[NUM_RES-1:0] = min_mask_ff;
            `OFS_TMR_CNT:  nxt_rdata[`TMR_W-1:0] = tcnt_ff;
            `OFS_TMR_MASK: nxt_rdata[NUM_RES-1:0] = tmask_ff;
            `OFS_ON_FLAGS: nxt_rdata[NUM_RES-1:0] = on_ff;
            `OFS_RAMP:     nxt_rdata[NUM_RES-1:0] = ramp_ff;
            `OFS_STATE:    nxt_rdata[2:0] = 3'(st_ff);
            default:
            begin
                for (int c = 0; c < NUM_CLK; c++)
                    if (haddr_in[7:0] == 8'(`OFS_CLK_MAP + 4 * c))
                        nxt_rdata[NUM_RES-1:0] = clk_map_ff[c];
                for (int r = 0; r < NUM_RES; r++)
                begin
                    if (haddr_in[7:0] == 8'(`OFS_RES_BASE + r * `RES_STRIDE))
                        nxt_rdata = {off_dly_ff[r], on_dly_ff[r]};
                    if (haddr_in[7:0] == 8'(`OFS_RES_BASE + r * `RES_STRIDE + 4))
                        nxt_rdata[NUM_RES-1:0] = dep_ff[r];
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            hrdata_out <= 32'h0000_0000;
        else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in)
            hrdata_out <= nxt_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // resource sequencer
    logic [NUM_RES-1:0] direct_req, need;
    always_comb
    begin
        direct_req = min_mask_ff | (tcnt_ff != '0 ? tmask_ff : '0);
        for (int c = 0; c < NUM_CLK; c++)
            if (clk_req_in[c])
                direct_req = direct_req | clk_map_ff[c];
        need = direct_req;
        for (int k = 0; k < NUM_RES; k++)
            for (int r = 0; r < NUM_RES; r++)
                if (need[r])
                    need = need | dep_ff[r];
    end

    logic [`TMR_W-1:0] tmr_ff [NUM_RES];
    generate
        for (g = 0; g < NUM_RES; g++)
        begin : g_seq
            logic deps_on;
            logic dependents_up;
            always_comb
            begin
                dependents_up = 1'b0;
                for (int j = 0; j < NUM_RES; j++)
                    if (dep_ff[j][g] && (on_ff[j] || ramp_ff[j]))
                        dependents_up = 1'b1;
            end
            assign deps_on = (dep_ff[g] & ~(on_ff & ~ramp_ff)) == '0;

            always_ff @(posedge mclk_in)
            begin
                if (cold)
                begin
                    tmr_ff[g]  <= '0;
                    on_ff[g]   <= 1'b0;
                    ramp_ff[g] <= 1'b0;
                end
                else if (tick)
                begin
                    if (tmr_ff[g] != '0)
                    begin
                        tmr_ff[g] <= tmr_ff[g] - 1'b1;
                        if (tmr_ff[g] == `TMR_W'(1))
                        begin
                            ramp_ff[g] <= 1'b0;
                            on_ff[g]   <= ~on_ff[g];
                        end
                    end
                    else if (on_ff[g] && !need[g] && !dependents_up)
                    begin
                        if (off_dly_ff[g] == '0)
                            on_ff[g] <= 1'b0;
                        else
                        begin
                            tmr_ff[g]  <= off_dly_ff[g];
                            ramp_ff[g] <= 1'b1;
                        end
                    end
                    else if (!on_ff[g] && need[g] && deps_on)
                    begin
                        if (on_dly_ff[g] == '0)
                            on_ff[g] <= 1'b1;
                        else
                        begin
                            tmr_ff[g]  <= on_dly_ff[g];
                            ramp_ff[g] <= 1'b1;
                        end
                    end
                end
            end

            chk_ramp_timer: assert property (@(posedge mclk_in) disable iff (rst_in)
                (ramp_ff[g] == (tmr_ff[g] != '0)))
                else $error("ramp flag and timer disagree");
            chk_timer_step: assert property (@(posedge mclk_in) disable iff (cold)
                (tick && tmr_ff[g] > `TMR_W'(1)) |=> (tmr_ff[g] == $past(tmr_ff[g]) - 1'b1))
                else $error("timer did not decrement by one");
            chk_flip_zero: assert property (@(posedge mclk_in) disable iff (cold)
                (tick && tmr_ff[g] == `TMR_W'(1)) |=> (on_ff[g] != $past(on_ff[g]) && !ramp_ff[g]))
                else $error("state not inverted at timer end");
            chk_enable_deps: assert property (@(posedge mclk_in) disable iff (cold)
                (!on_ff[g] && !ramp_ff[g]) ##1 (on_ff[g] || ramp_ff[g]) |-> $past(deps_on && need[g]))
                else $error("enable started without dependencies");
            chk_disable_ok: assert property (@(posedge mclk_in) disable iff (cold)
                (on_ff[g] && !ramp_ff[g]) ##1 (!on_ff[g] || ramp_ff[g]) |->
                $past(!need[g] && !dependents_up))
                else $error("disable started while still needed");
        end
    endgenerate
    assign resource_en_out = on_ff;

    ////////////////////////////////////////////////////////////////////////
    // power state machine
    logic [RET_W-1:0] ret_mem [1];
    pwr_state_t       nxt_st;
    assign wake = tmr_expire | pin_ff.ext_wake | pin_ff.host_resume;

    always_comb
    begin
        nxt_st = st_ff;
        unique case (st_ff)
            ST_OFF:     nxt_st = ST_ACTIVE;
            ST_ACTIVE:
            begin
                if (mode_ff == MODE_DOZE)
                    nxt_st = ST_DOZE;
                else if (mode_ff == MODE_DEEP_SLEEP)
                    nxt_st = ST_SAVE;
            end
            ST_DOZE:    nxt_st = (wake || mode_ff == MODE_ACTIVE) ? ST_ACTIVE : ST_DOZE;
            ST_SAVE:    nxt_st = ST_SLEEP;
            ST_SLEEP:   nxt_st = (wake || mode_ff == MODE_ACTIVE) ? ST_RESTORE : ST_SLEEP;
            ST_RESTORE: nxt_st = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (cold)
            st_ff <= ST_OFF;
        else
            st_ff <= nxt_st;
    end

    always_ff @(posedge mclk_in)
    begin
        if (cold)
            ret_mem[0] <= '0;
        else if (st_ff == ST_SAVE)
            ret_mem[0] <= core_state_in;
    end
    assign core_state_out   = ret_mem[0];
    assign core_restore_out = (st_ff == ST_RESTORE);

    assign core_buck_regulator_en_out        = any_req;
    assign core_linear_regulator_en_out      = any_req;
    assign low_noise_linear_regulator_en_out = any_req;
    assign radio_rst_out = ~pin_ff.radio;
    assign wlan_rst_out  = ~pin_ff.wlan;
    assign io_oe_n_out  = ~any_req;
    assign input_en_out = any_req;
    // doze and sleep stop main clocks
    assign main_clk_en_out   = st_ff inside {ST_ACTIVE, ST_SAVE, ST_RESTORE};
    // gated by the requests so core power drops in the same cycle as the regulators
    assign core_power_en_out = any_req && st_ff != ST_SLEEP && st_ff != ST_OFF;

    // gate unused clocks; slowest adequate speed
    always_comb
    begin
        clk_gate_en_out = (st_ff == ST_ACTIVE) ? clk_req_in : '0;
        clk_speed_out   = 2'h0;
        for (int c = 0; c < NUM_CLK; c++)
            if (clk_gate_en_out[c])
                clk_speed_out = 2'(c);
    end

    chk_regs_off: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!pin_ff.radio && !pin_ff.wlan) |-> !core_buck_regulator_en_out && !core_power_en_out)
        else $error("regulator on with both requests low");
    chk_save_first: assert property (@(posedge mclk_in) disable iff (cold)
        (st_ff == ST_SLEEP && $past(st_ff) != ST_SLEEP) |-> $past(st_ff) == ST_SAVE
        && ret_mem[0] == $past(core_state_in))
        else $error("sleep entered without saving state");
    chk_doze_clock: assert property (@(posedge mclk_in) disable iff (cold)
        (st_ff == ST_DOZE && wake) |=> main_clk_en_out)
        else $error("doze wake did not restart clocks");
    chk_wake_restore: assert property (@(posedge mclk_in) disable iff (cold)
        (st_ff == ST_SLEEP && wake) |=> core_restore_out ##1 st_ff == ST_ACTIVE)
        else $error("deep-sleep wake did not restore");
    chk_cold_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
        !any_req |=> on_ff == '0 && ret_mem[0] == '0)
        else $error("state kept across shutdown");
    chk_sect_reset: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wlan_rst_out == !pin_ff.wlan) && (radio_rst_out == !pin_ff.radio))
        else $error("section reset wrong");

    cov_ramp_up: cover property (@(posedge mclk_in) disable iff (cold)
        ramp_ff[0] && !on_ff[0] ##[1:300] on_ff[0] && !ramp_ff[0]);
    cov_doze: cover property (@(posedge mclk_in) disable iff (cold)
        st_ff == ST_DOZE ##1 st_ff == ST_ACTIVE);
    cov_sleep: cover property (@(posedge mclk_in) disable iff (cold)
        st_ff == ST_SAVE ##1 st_ff == ST_SLEEP);

endmodule // power_sequencer
`default_nettype wire

// [hw/pwr_seq_defines.svh]
`ifndef PWR_SEQ_DEFINES_SVH
`define PWR_SEQ_DEFINES_SVH
// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_MIN_MASK  8'h04
`define OFS_TMR_CNT   8'h08
`define OFS_TMR_MASK  8'h0C
`define OFS_ON_FLAGS  8'h10
`define OFS_RAMP      8'h14
`define OFS_STATE     8'h18
`define OFS_CLK_MAP   8'h20
`define OFS_RES_BASE  8'h40
`define RES_STRIDE    8'h08
// control field positions
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
// reset values
`define RST_MIN_MASK  32'h0000_0001
`define RST_DELAY     16'h0000
// timing: sequencer ticks once per oscillator cycle
`define TMR_W         16
`endif

// [hw/pwr_seq_pkg.sv]
`default_nettype none
package pwr_seq_pkg;
    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_DOZE,
        MODE_DEEP_SLEEP
    } mode_t;
    typedef enum {
        ST_OFF,
        ST_ACTIVE,
        ST_DOZE,
        ST_SAVE,
        ST_SLEEP,
        ST_RESTORE
    } pwr_state_t;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
    } bus_req_t;
    typedef struct packed {
        logic        low_power_oscillator_clock;
        logic        radio;
        logic        wlan;
        logic        ext_wake;
        logic        host_resume;
    } pins_t;
endpackage
`default_nettype wire

// [verif/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // clock and commands
    input  wire logic mclk_in,
    input  wire logic radio_cmd_in,
    input  wire logic wlan_cmd_in,
    // request pins
    output logic      radio_power_request_out,
    output logic      wlan_power_request_out
);
    always_ff @(posedge mclk_in)
    begin
        radio_power_request_out <= radio_cmd_in;
        wlan_power_request_out  <= wlan_cmd_in;
    end
endmodule // host_model
`default_nettype wire

// [verif/pmu_resource_sequencer_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pwr_seq_defines.svh"
module pmu_resource_sequencer_tb_top;
    logic        mclk, rst, hwrite, hrdy, low_power_oscillator_clock, rcmd, wcmd, rreq, wreq, wake, resume, restore;
    logic        bk, cl, ln, rrst, wrst, cpe, mce, oen, ien, hresp;
    logic [1:0]  htrans, spd;
    logic [3:0]  creq, cgate;
    logic [7:0]  res_en;
    logic [31:0] haddr, hwdata, hrdata, cst_in, cst_out, rd, saved;
    int          error_cnt, checks, n;

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // oscillator runs fast so that a tick is 20 clocks
    initial
    begin
        low_power_oscillator_clock = 1'b0;
        forever #500 low_power_oscillator_clock = ~low_power_oscillator_clock;
    end

    power_sequencer dut (.mclk_in(mclk), .rst_in(rst), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
        .hreadyout_out(hrdy), .hresp_out(hresp), .low_power_oscillator_clock_in(low_power_oscillator_clock),
        .radio_power_request_in(rreq), .wlan_power_request_in(wreq), .ext_wake_in(wake),
        .host_resume_in(resume), .clk_req_in(creq), .core_state_in(cst_in), .core_state_out(cst_out),
        .core_restore_out(restore), .core_buck_regulator_en_out(bk), .core_linear_regulator_en_out(cl),
        .low_noise_linear_regulator_en_out(ln), .radio_rst_out(rrst), .wlan_rst_out(wrst),
        .resource_en_out(res_en), .core_power_en_out(cpe), .main_clk_en_out(mce), .clk_gate_en_out(cgate),
        .clk_speed_out(spd), .io_oe_n_out(oen), .input_en_out(ien));
    host_model host (.mclk_in(mclk), .radio_cmd_in(rcmd), .wlan_cmd_in(wcmd),
        .radio_power_request_out(rreq), .wlan_power_request_out(wreq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdy_wait;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hrdy !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            chk(32'h1, 32'h0);
            end_sim();
        end
    endtask
    // address phase held until hready, then data phase until hready
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        rdy_wait();
        htrans <= 2'h0;
        hwdata <= d;
        rdy_wait();
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask
    // expected pins worked out from the request levels
    task automatic pwr(input logic r, input logic w);
        rcmd <= r;
        wcmd <= w;
        repeat (12) @(posedge mclk);
        chk(32'({bk, cl, ln, rrst, wrst, oen, ien}), 32'({{3{r | w}}, ~r, ~w, ~(r | w), r | w}));
    endtask

    initial
    begin
        error_cnt = 0;
        checks = 0;
        void'($urandom(32'h0A58));
        rst = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rcmd = 1'b0;
        wcmd = 1'b0;
        wake = 1'b0;
        resume = 1'b0;
        creq = 4'h0;
        cst_in = 32'h0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        pwr(1'b0, 1'b0);
        pwr(1'b1, 1'b0);
        pwr(1'b1, 1'b1);
        pwr(1'b0, 1'b1);
        pwr(1'b1, 1'b1);
        bus(1'b0, `OFS_MIN_MASK, 32'h0);
        chk(rd, `RST_MIN_MASK);
        bus(1'b0, 32'h3C, 32'h0);
        chk(rd, 32'h0);
        repeat (40) @(posedge mclk);
        bus(1'b0, `OFS_ON_FLAGS, 32'h0);
        chk(rd, 32'h1);
        chk(32'(res_en), 32'h1);
        bus(1'b1, 32'h48, 32'h0000_0003);
        bus(1'b1, 32'h4C, 32'h0000_0001);
        bus(1'b1, `OFS_MIN_MASK, 32'h3);
        for (int i = 0; i < 40 && rd[1] !== 1'b1; i++)
            bus(1'b0, `OFS_RAMP, 32'h0);
        chk(rd, 32'h2);
        repeat (40) @(posedge mclk);
        chk(32'(res_en), 32'h1);
        repeat (40) @(posedge mclk);
        chk(32'(res_en), 32'h3);
        bus(1'b0, `OFS_RAMP, 32'h0);
        chk(rd, 32'h0);
        creq <= 4'($urandom);
        bus(1'b1, `OFS_MIN_MASK, 32'h1);
        chk(32'(cgate), 32'(creq));
        // slowest adequate speed: index of the highest requested clock
        n = 0;
        for (int i = 0; i < 4; i++)
            if (creq[i])
                n = i;
        chk(32'(spd), 32'(n));
        repeat (50) @(posedge mclk);
        chk(32'(res_en), 32'h1);
        bus(1'b1, `OFS_CTRL, 32'h1);
        repeat (4) @(posedge mclk);
        chk(32'({mce, cgate}), 32'h0);
        resume <= 1'b1;
        repeat (12) @(posedge mclk);
        resume <= 1'b0;
        bus(1'b0, `OFS_STATE, 32'h0);
        chk(rd, 32'h1);
        // request timer holds resource 1 up for 8 ticks, then its expiry wakes doze
        bus(1'b1, `OFS_TMR_MASK, 32'h2);
        bus(1'b1, `OFS_TMR_CNT, 32'h8);
        repeat (100) @(posedge mclk);
        chk(32'(res_en), 32'h3);
        bus(1'b1, `OFS_CTRL, 32'h1);
        repeat (100) @(posedge mclk);
        chk(32'({mce, res_en}), 32'h101);
        saved = $urandom;
        cst_in <= saved;
        bus(1'b1, `OFS_CTRL, 32'h2);
        repeat (4) @(posedge mclk);
        cst_in <= ~saved;
        chk(32'(cpe), 32'h0);
        wake <= 1'b1;
        for (int i = 0; i < 20 && restore !== 1'b1; i++)
            @(posedge mclk);
        chk(32'(restore), 32'h1);
        chk(cst_out, saved);
        wake <= 1'b0;
        pwr(1'b0, 1'b0);
        pwr(1'b0, 1'b1);
        bus(1'b0, `OFS_MIN_MASK, 32'h0);
        chk(rd, `RST_MIN_MASK);
        bus(1'b0, `OFS_TMR_MASK, 32'h0);
        chk(rd, 32'h0);
        end_sim();
    end
endmodule // pmu_resource_sequencer_tb_top
`default_nettype wire
